/* File: core/eagu_pkg.sv */
// Purpose: Shared constants and carrier types for the effective address generator.
// Assumes: 16-bit data addresses, byte addressed, registers reached over classic Wishbone.
// Notes:   All offsets, field positions and reset values live here.
`default_nettype none
package eagu_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0]  OFS_MODCTL   = 8'h00;
	localparam logic [7:0]  OFS_XSTART   = 8'h04;
	localparam logic [7:0]  OFS_XEND     = 8'h08;
	localparam logic [7:0]  OFS_YSTART   = 8'h0C;
	localparam logic [7:0]  OFS_YEND     = 8'h10;
	localparam logic [7:0]  OFS_STATUS   = 8'h14;
	// Reset values; both pointer selects start at 15 so no buffer is armed.
	localparam logic [15:0] RST_MODCTL   = 16'h00FF;
	localparam logic [15:0] RST_BOUND    = 16'h0000;
	// Control field positions.
	localparam int          XSEL_LSB     = 0;
	localparam int          YSEL_LSB     = 4;
	localparam int          XEN_BIT      = 15;
	localparam int          YEN_BIT      = 14;
	localparam logic [3:0]  SEL_NONE     = 4'hF;
	// Status field positions.
	localparam int          ST_WRAP_BIT  = 0;
	localparam int          ST_ILL_BIT   = 1;
	// Instruction-level constants.
	localparam int          FILE_ADDR_W  = 13;
	localparam logic [3:0]  DEFAULT_DEFAULT_WORKING_REGISTER = 4'h0;
	localparam logic [3:0]  MAC_X_LO     = 4'h8;
	localparam logic [3:0]  MAC_X_IDX    = 4'h9;
	localparam logic [3:0]  MAC_Y_LO     = 4'hA;
	localparam logic [3:0]  MAC_Y_IDX    = 4'hB;
	localparam logic [15:0] MAC_STEP_1   = 16'h0002;
	localparam logic [15:0] MAC_STEP_2   = 16'h0004;
	localparam logic [15:0] MAC_STEP_3   = 16'h0006;

	typedef enum logic [7:0] {
		M_FILE  = 8'b0000_0001,
		M_DIR   = 8'b0000_0010,
		M_IND   = 8'b0000_0100,
		M_POST  = 8'b0000_1000,
		M_PRE   = 8'b0001_0000,
		M_ROFS  = 8'b0010_0000,
		M_LOFS  = 8'b0100_0000,
		M_LIT   = 8'b1000_0000
	} eagu_mode_e;

	typedef enum logic [4:0] {
		C_FILE  = 5'b00001,
		C_MCU   = 5'b00010,
		C_MOVE  = 5'b00100,
		C_MAC   = 5'b01000,
		C_OTHER = 5'b10000
	} eagu_class_e;

	typedef enum logic [2:0] {
		S_XR    = 3'b001,
		S_XW    = 3'b010,
		S_Y     = 3'b100
	} eagu_space_e;

	typedef enum logic [5:0] {
		L_5     = 6'b000001,
		L_10    = 6'b000010,
		L_8     = 6'b000100,
		L_16    = 6'b001000,
		L_BRA   = 6'b010000,
		L_INTERRUPT_DISABLE_INSTRUCTION  = 6'b100000
	} eagu_lit_e;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} eagu_wb_req_s;

	typedef struct packed {
		logic        valid;
		eagu_class_e cls;
		eagu_mode_e  mode;
		eagu_space_e space;
		eagu_lit_e   lit_kind;
		logic [3:0]  ptr_sel;
		logic [15:0] ptr_val;
		logic [3:0]  ofs_sel;
		logic [15:0] ofs_val;
		logic [15:0] literal;
		logic [15:0] step;
	} eagu_req_s;

	typedef struct packed {
		logic        valid;
		eagu_space_e space;
		logic [15:0] ea;
		logic [15:0] operand;
		logic [3:0]  dst_sel;
		logic        wb_en;
		logic [3:0]  wb_sel;
		logic [15:0] wb_val;
		logic        wrapped;
		logic        illegal;
	} eagu_rsp_s;

	typedef struct packed {
		logic [15:0] modctl;
		logic [15:0] xstart;
		logic [15:0] xend;
		logic [15:0] ystart;
		logic [15:0] yend;
		logic [1:0]  status;
		logic        ack;
		logic [15:0] rdata;
		eagu_rsp_s   rsp;
	} eagu_state_s;
endpackage
`default_nettype wire

/* File: core/eagu_top.sv */
// Purpose: Effective address generation with X and Y circular buffer correction.
// Assumes: The decoder presents one operand per request with the pointer and offset values already read.
// Notes:   One cycle from request to answer; the configuration registers sit on a Wishbone slave.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`default_nettype none
// Behaviour
// - File direct uses 13-bit address, default register zero.
// - Three-operand base is direct; operand register or 5-bit.
// - Three-operand: direct, indirect, pre, post, 5/10-bit literal.
// - Post-modify: address is pointer, then pointer steps.
// - Pre-modify: pointer steps first, result is address.
// - Register offset: pointer plus offset register.
// - Literal offset: pointer plus instruction literal.
// - Move adds indexed, literal offset, 8/16-bit literals.
// - Move source and destination share one offset field.
// - Multiply-accumulate pointers eight to eleven, fixed spaces.
// - Multiply-accumulate indexing only via nine and eleven.
// - Multiply-accumulate: indirect, post by 2/4/6, indexed.
// - Branch literal 16-bit signed, interrupt-disable 14-bit unsigned.
// - One circular buffer in X, one in Y.
// - Power-of-two buffers check both limits; others one.
// - Four 16-bit boundary registers hold the limits.
// - X select bits 3:0, enable bit 15.
// - Y select bits 7:4, enable bit 14.
// - Y modulo addresses keep the low bit clear.
// - Limits compare beyond, not only equal.
// - Pointer written back only in pre or post modes.
module eagu_top (
	input  wire logic                   mclk,
	input  wire logic                   srst,
	input  wire eagu_pkg::eagu_wb_req_s wb_req,
	output logic                        wb_ack,
	output logic [31:0]                 wb_dat_o,
	input  wire eagu_pkg::eagu_req_s    req,
	output eagu_pkg::eagu_rsp_s         rsp
);
	import eagu_pkg::*;

	eagu_state_s state;
	eagu_state_s next_state;

	// One-hot register decode, shared by the read mux and the write path.
	function automatic logic [5:0] reg_hit(input logic [7:0] adr);
		logic [5:0] h;
		h = 6'h00;
		h[0] = (adr == OFS_MODCTL);
		h[1] = (adr == OFS_XSTART);
		h[2] = (adr == OFS_XEND);
		h[3] = (adr == OFS_YSTART);
		h[4] = (adr == OFS_YEND);
		h[5] = (adr == OFS_STATUS);
		return h;
	endfunction

	// Byte-lane merge; only the two low lanes carry register bits.
	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = d[7:0];
		end
		if (sel[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction

	// Literal extension by field width; the branch literal is already full width and signed.
	function automatic logic [15:0] lit_ext(input eagu_lit_e k, input logic [15:0] l);
		logic [15:0] r;
		r = 16'h0000;
		unique case (k)
			L_5: begin
				r = {11'h000, l[4:0]};
			end
			L_10: begin
				r = {6'h00, l[9:0]};
			end
			L_8: begin
				r = {8'h00, l[7:0]};
			end
			L_16, L_BRA: begin
				r = l;
			end
			L_INTERRUPT_DISABLE_INSTRUCTION: begin
				r = {2'h0, l[13:0]};
			end
			default: begin
				r = 16'h0000;
			end
		endcase
		return r;
	endfunction

	// Circular correction. Comparing with greater/less than rather than equality lets a
	// step larger than one element overshoot and still land inside the buffer.
	function automatic logic [15:0] mod_fix(input logic [15:0] a, input logic neg,
		input logic [15:0] s, input logic [15:0] e);
		logic [15:0] len;
		logic        pow2;
		logic [15:0] r;
		len  = e - s + 16'h0001;
		pow2 = ((len & (len - 16'h0001)) == 16'h0000);
		r    = a;
		if ((pow2 || !neg) && (a > e)) begin
			r = s + (a - e - 16'h0001);
		end else if ((pow2 || neg) && (a < s)) begin
			r = e - (s - a) + 16'h0001;
		end
		return r;
	endfunction

	// Datapath terms.
	logic [5:0]  hit;
	eagu_space_e eff_space;
	logic        is_x;
	logic        mod_act;
	logic [15:0] bstart;
	logic [15:0] bend;
	logic [15:0] addend;
	logic [15:0] sum;
	logic [15:0] fixed;
	logic        mac_bad;
	logic        mode_bad;
	logic        bad;

	// Multiply-accumulate pointers pick their own space and must obey the narrow mode set.
	always_comb begin
		eff_space = req.space;
		mac_bad   = 1'b0;
		if (req.cls == C_MAC) begin
			if (req.ptr_sel == MAC_X_LO || req.ptr_sel == MAC_X_IDX) begin
				eff_space = S_XR;
			end else if (req.ptr_sel == MAC_Y_LO || req.ptr_sel == MAC_Y_IDX) begin
				eff_space = S_Y;
			end else begin
				mac_bad = 1'b1;
			end
			if (req.mode == M_ROFS && req.ptr_sel != MAC_X_IDX && req.ptr_sel != MAC_Y_IDX) begin
				mac_bad = 1'b1;
			end
			if (req.mode != M_IND && req.mode != M_POST && req.mode != M_ROFS) begin
				mac_bad = 1'b1;
			end
			if (req.mode == M_POST && req.step != MAC_STEP_1 && req.step != MAC_STEP_2
				&& req.step != MAC_STEP_3 && req.step != (16'h0000 - MAC_STEP_1)
				&& req.step != (16'h0000 - MAC_STEP_2) && req.step != (16'h0000 - MAC_STEP_3)) begin
				mac_bad = 1'b1;
			end
		end
	end

	// Mode sets allowed by each instruction class.
	always_comb begin
		mode_bad = 1'b0;
		unique case (req.cls)
			C_FILE: begin
				mode_bad = (req.mode != M_FILE);
			end
			C_MCU: begin
				mode_bad = (req.mode == M_ROFS) || (req.mode == M_LOFS) || (req.mode == M_FILE)
					|| (req.mode == M_LIT && req.lit_kind != L_5 && req.lit_kind != L_10);
			end
			C_MOVE: begin
				mode_bad = (req.mode == M_LIT && req.lit_kind != L_8 && req.lit_kind != L_16);
			end
			C_MAC: begin
				mode_bad = 1'b0;
			end
			C_OTHER: begin
				mode_bad = (req.mode != M_LIT) || (req.lit_kind != L_BRA && req.lit_kind != L_INTERRUPT_DISABLE_INSTRUCTION);
			end
			default: begin
				mode_bad = 1'b1;
			end
		endcase
	end

	// Buffer selection: one buffer per space, the X one shared by read and write.
	always_comb begin
		is_x   = (eff_space == S_XR) || (eff_space == S_XW);
		bstart = is_x ? state.xstart : state.ystart;
		bend   = is_x ? state.xend : state.yend;
		if (is_x) begin
			mod_act = state.modctl[XEN_BIT] && (state.modctl[XSEL_LSB +: 4] != SEL_NONE)
				&& (state.modctl[XSEL_LSB +: 4] == req.ptr_sel);
		end else begin
			mod_act = state.modctl[YEN_BIT] && (state.modctl[YSEL_LSB +: 4] != SEL_NONE)
				&& (state.modctl[YSEL_LSB +: 4] == req.ptr_sel);
		end
	end

	// The adder sees the offset register, the literal or the step, by mode. A move presents the
	// same offset value for source and destination, so one input serves both.
	always_comb begin
		unique case (req.mode)
			M_ROFS: begin
				addend = req.ofs_val;
			end
			M_LOFS: begin
				addend = req.literal;
			end
			M_PRE, M_POST: begin
				addend = req.step;
			end
			default: begin
				addend = 16'h0000;
			end
		endcase
		sum   = req.ptr_val + addend;
		fixed = sum;
		if (mod_act && req.mode != M_IND) begin
			fixed = mod_fix(sum, addend[15], bstart, bend);
			if (!is_x) begin
				fixed[0] = 1'b0;
			end
		end
		bad = mac_bad || mode_bad;
	end

	assign hit = reg_hit(wb_req.adr);

	// Next state: bus slave, configuration registers and the registered answer.
	always_comb begin
		next_state     = state;
		next_state.ack = wb_req.cyc && wb_req.stb && !state.ack;
		if (next_state.ack) begin
			unique case (1'b1)
				hit[0]: begin
					next_state.rdata = state.modctl;
				end
				hit[1]: begin
					next_state.rdata = state.xstart;
				end
				hit[2]: begin
					next_state.rdata = state.xend;
				end
				hit[3]: begin
					next_state.rdata = state.ystart;
				end
				hit[4]: begin
					next_state.rdata = state.yend;
				end
				hit[5]: begin
					next_state.rdata = {14'h0000, state.status};
				end
				default: begin
					next_state.rdata = 16'h0000;
				end
			endcase
			if (wb_req.we) begin
				if (hit[0]) begin
					next_state.modctl = lane_merge(state.modctl, wb_req.dat, wb_req.sel);
				end
				if (hit[1]) begin
					next_state.xstart = lane_merge(state.xstart, wb_req.dat, wb_req.sel);
				end
				if (hit[2]) begin
					next_state.xend = lane_merge(state.xend, wb_req.dat, wb_req.sel);
				end
				if (hit[3]) begin
					next_state.ystart = lane_merge(state.ystart, wb_req.dat, wb_req.sel);
				end
				if (hit[4]) begin
					next_state.yend = lane_merge(state.yend, wb_req.dat, wb_req.sel);
				end
			end
		end
		next_state.rsp         = '0;
		next_state.rsp.valid   = req.valid;
		next_state.rsp.space   = eff_space;
		next_state.rsp.illegal = req.valid && bad;
		next_state.rsp.wb_sel  = req.ptr_sel;
		next_state.rsp.dst_sel = req.ptr_sel;
		if (req.valid && !bad) begin
			unique case (req.mode)
				M_FILE: begin
					next_state.rsp.ea      = {3'h0, req.literal[FILE_ADDR_W-1:0]};
					next_state.rsp.dst_sel = DEFAULT_DEFAULT_WORKING_REGISTER;
				end
				M_DIR: begin
					next_state.rsp.operand = req.ptr_val;
				end
				M_IND: begin
					next_state.rsp.ea = req.ptr_val;
				end
				M_POST: begin
					next_state.rsp.ea      = req.ptr_val;
					next_state.rsp.wb_en   = 1'b1;
					next_state.rsp.wb_val  = fixed;
					next_state.rsp.wrapped = (fixed != sum);
				end
				M_PRE: begin
					next_state.rsp.ea      = fixed;
					next_state.rsp.wb_en   = 1'b1;
					next_state.rsp.wb_val  = fixed;
					next_state.rsp.wrapped = (fixed != sum);
				end
				M_ROFS, M_LOFS: begin
					next_state.rsp.ea      = fixed;
					next_state.rsp.wrapped = (fixed != sum);
				end
				M_LIT: begin
					next_state.rsp.operand = lit_ext(req.lit_kind, req.literal);
				end
				default: begin
					next_state.rsp.illegal = 1'b1;
				end
			endcase
		end
		if (req.valid) begin
			next_state.status[ST_WRAP_BIT] = next_state.rsp.wrapped;
			next_state.status[ST_ILL_BIT]  = next_state.rsp.illegal;
		end
	end

	// State register; reset parks both buffers with select 15.
	always_ff @(posedge mclk) begin
		if (srst) begin
			state        <= '0;
			state.modctl <= RST_MODCTL;
			state.xstart <= RST_BOUND;
			state.xend   <= RST_BOUND;
			state.ystart <= RST_BOUND;
			state.yend   <= RST_BOUND;
		end else begin
			state <= next_state;
		end
	end

	assign wb_ack   = state.ack;
	assign wb_dat_o = {16'h0000, state.rdata};
	assign rsp      = state.rsp;

	// Checks.
	sequence bus_req_s;
		wb_req.cyc && wb_req.stb && !wb_ack;
	endsequence

	sequence bus_ack_s;
		wb_ack ##1 !wb_ack;
	endsequence

	bus_ack_pulse_a: assert property (@(posedge mclk) disable iff (srst) bus_req_s |=> bus_ack_s)
		else $error("Bus ack is not a one-cycle pulse after a request.");

	rsp_latency_a: assert property (@(posedge mclk) disable iff (srst) req.valid |=> rsp.valid)
		else $error("Answer missing one cycle after a request.");

	file_addr_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && req.cls == C_FILE && req.mode == M_FILE
		|=> rsp.ea == {3'h0, $past(req.literal[12:0])} && rsp.dst_sel == 4'h0)
		else $error("File direct address or default register wrong.");

	post_ea_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && !bad && req.mode == M_POST |=> rsp.ea == $past(req.ptr_val) && rsp.wb_en)
		else $error("Post-modify address is not the old pointer.");

	offset_nowb_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && (req.mode == M_ROFS || req.mode == M_LOFS) |=> !rsp.wb_en)
		else $error("Offset mode wrote the pointer back.");

	mac_range_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && req.cls == C_MAC && (req.ptr_sel < 4'h8 || req.ptr_sel > 4'hB) |=> rsp.illegal)
		else $error("Multiply-accumulate pointer outside eight to eleven accepted.");

	x_off_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && is_x && state.modctl[3:0] == 4'hF |=> !rsp.wrapped)
		else $error("X address wrapped with select 15.");

	y_enable_a: assert property (@(posedge mclk) disable iff (srst)
		req.valid && !is_x && !state.modctl[14] |=> !rsp.wrapped)
		else $error("Y address wrapped with Y disabled.");

	x_inside_a: assert property (@(posedge mclk) disable iff (srst)
		rsp.valid && rsp.wrapped && rsp.space != S_Y && $stable(state.xstart) && $stable(state.xend)
		|-> (rsp.wb_en ? rsp.wb_val : rsp.ea) >= state.xstart && (rsp.wb_en ? rsp.wb_val : rsp.ea) <= state.xend)
		else $error("Wrapped X address left the buffer.");

	y_lsb_a: assert property (@(posedge mclk) disable iff (srst)
		rsp.valid && rsp.wrapped && rsp.space == S_Y |-> !(rsp.wb_en ? rsp.wb_val[0] : rsp.ea[0]))
		else $error("Wrapped Y address has the low bit set.");
endmodule
`default_nettype wire

/* File: bench/eagu_core_model.sv */
// Purpose: Working-register side of the generator: supplies pointer and offset values, takes writebacks.
// Assumes: Requests are spaced so a writeback lands before the same register is read again.
// Notes:   A load port lets the bench seed registers; a load outranks a writeback in the same cycle.
`default_nettype none
module eagu_core_model (
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                ld_en,
	input  wire logic [3:0]          ld_sel,
	input  wire logic [15:0]         ld_val,
	input  wire eagu_pkg::eagu_req_s cmd,
	input  wire eagu_pkg::eagu_rsp_s rsp,
	output var  eagu_pkg::eagu_req_s req
);
	timeunit 1ns;
	timeprecision 1ps;
	import eagu_pkg::*;
	logic [15:0] default_working_register [16];

	// Values come from the register file; the offset field is shared by source and destination.
	always_comb begin
		req         = cmd;
		req.ptr_val = default_working_register[cmd.ptr_sel];
		req.ofs_val = default_working_register[cmd.ofs_sel];
	end

	// Writebacks land at the answer edge, so the next read sees the corrected pointer.
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < 16; i++) begin
				default_working_register[i] <= 16'h0000;
			end
		end else if (ld_en) begin
			default_working_register[ld_sel] <= ld_val;
		end else if (rsp.valid && rsp.wb_en) begin
			default_working_register[rsp.wb_sel] <= rsp.wb_val;
		end
	end
endmodule
`default_nettype wire

/* File: bench/effective_address_generator_modulo_bench.sv */
// Purpose: Self-checking bench for the effective address generator with circular buffers.
// Assumes: One answer a cycle after each request; the bus slave answers in its own time.
// Notes:   Requests are spaced apart because the register model has no forwarding path.
`default_nettype none
module effective_address_generator_modulo_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import eagu_pkg::*;
	logic         mclk, srst, ld_en, wb_ack;
	logic [3:0]   ld_sel;
	logic [15:0]  ld_val, rd, pv;
	logic [31:0]  wb_dat_o;
	eagu_wb_req_s wb_req;
	eagu_req_s    cmd, req;
	eagu_rsp_s    rsp, r;
	int           error_cnt, num_checks, cyc_cnt;
	eagu_lit_e    lk_t [6] = '{L_5, L_10, L_8, L_16, L_BRA, L_INTERRUPT_DISABLE_INSTRUCTION};
	eagu_class_e  cl_t [6] = '{C_MCU, C_MCU, C_MOVE, C_MOVE, C_OTHER, C_OTHER};
	logic [15:0]  mk_t [6] = '{16'h001F, 16'h03FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'h3FFF};
	logic [3:0]   mp_t [8] = '{4'h9, 4'hB, 4'h8, 4'hA, 4'h8, 4'h5, 4'hA, 4'h8};
	eagu_mode_e   mm_t [8] = '{M_ROFS, M_ROFS, M_ROFS, M_ROFS, M_LOFS, M_IND, M_IND, M_POST};
	logic         mi_t [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};

	eagu_top uut (.mclk(mclk), .srst(srst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
		.req(req), .rsp(rsp));
	eagu_core_model partner (.mclk(mclk), .srst(srst), .ld_en(ld_en), .ld_sel(ld_sel), .ld_val(ld_val),
		.cmd(cmd), .rsp(rsp), .req(req));

	// Free-running core clock.
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Single exit for the normal end and the hang guard.
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Hang guard; the sequence needs only a few hundred cycles.
	always @(posedge mclk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Classic single cycle; the request is held until ack is sampled, then released for a cycle.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h3, adr: adr, dat: {16'h0000, d}};
		do begin
			@(posedge mclk);
			n++;
		end while (wb_ack !== 1'b1 && n < 40);
		chk("wb upper", {n < 40, wb_dat_o[31:16]}, 17'h10000);
		rd = wb_dat_o[15:0];
		wb_req <= '0;
	endtask

	function automatic eagu_req_s mk(eagu_class_e c, eagu_mode_e m, eagu_space_e sp, eagu_lit_e lk,
			logic [3:0] ps, logic [3:0] os, logic [15:0] lit, logic [15:0] st);
		return '{valid: 1'b1, cls: c, mode: m, space: sp, lit_kind: lk, ptr_sel: ps, ptr_val: 16'h0000,
			ofs_sel: os, ofs_val: 16'h0000, literal: lit, step: st};
	endfunction

	// Expected correction: power-of-two buffers check both limits, others only the side the step heads to.
	function automatic logic [15:0] wrap(logic [15:0] a, logic [15:0] s, logic [15:0] e, logic neg, logic ysp);
		logic [15:0] len, v;
		len = e - s + 16'h0001;
		v = a;
		if (a > e && ((len & (len - 16'h0001)) == 16'h0000 || !neg)) begin
			v = s + (a - e - 16'h0001);
		end else if (a < s && ((len & (len - 16'h0001)) == 16'h0000 || neg)) begin
			v = e - (s - a) + 16'h0001;
		end
		if (ysp) begin
			v[0] = 1'b0;
		end
		return v;
	endfunction

	// Seeds offset then pointer, issues one request and samples the one-cycle answer.
	task automatic op(input eagu_req_s c, input logic [15:0] p, input logic [15:0] o);
		@(posedge mclk);
		ld_en <= 1'b1;
		ld_sel <= c.ofs_sel;
		ld_val <= o;
		@(posedge mclk);
		ld_sel <= c.ptr_sel;
		ld_val <= p;
		@(posedge mclk);
		ld_en <= 1'b0;
		cmd <= c;
		@(posedge mclk);
		cmd.valid <= 1'b0;
		@(posedge mclk);
		r = rsp;
	endtask

	// One access that may be corrected; checks address, wrap flag and the pointer left behind.
	task automatic mod(input eagu_class_e c, input eagu_mode_e m, input eagu_space_e sp, input logic [3:0] ps,
			input logic [15:0] p, input logic [15:0] st, input logic on, input logic [15:0] s, input logic [15:0] e);
		logic [15:0] a, x;
		a = p + st;
		x = on ? wrap(a, s, e, st[15], sp == S_Y) : a;
		op(mk(c, m, sp, L_5, ps, 4'h0, st, st), p, 16'h0000);
		@(posedge mclk);
		chk("mod ea", r.ea, (m == M_POST) ? p : x);
		chk("wrap flag", r.wrapped, x != a);
		chk("pointer after", partner.default_working_register[ps], (m == M_LOFS) ? p : x);
	endtask

	initial begin
		srst = 1'b1;
		ld_en = 1'b0;
		ld_sel = 4'h0;
		ld_val = 16'h0000;
		wb_req = '0;
		cmd = '0;
		pv = 16'($urandom(68694));
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		// Reset values, then random write and read back of each bound, then an unmapped place.
		wb(1'b0, OFS_MODCTL, 16'h0000);
		chk("modctl reset", rd, RST_MODCTL);
		for (int a = 4; a <= 16; a += 4) begin
			wb(1'b0, 8'(a), 16'h0000);
			chk("bound reset", rd, RST_BOUND);
			pv = 16'($urandom);
			wb(1'b1, 8'(a), pv);
			wb(1'b0, 8'(a), 16'h0000);
			chk("bound rw", rd, pv);
		end
		wb(1'b1, 8'h18, 16'hBEEF);
		wb(1'b0, 8'h18, 16'h0000);
		chk("unmapped", rd, 16'h0000);
		// Random offset, post and pre forms with no buffer armed: the sum is the address or new pointer, offsets keep the pointer.
		repeat (12) begin
			pv = 16'($urandom);
			rd = 16'($urandom);
			op(mk(C_MOVE, M_ROFS, S_XR, L_8, 4'h3, 4'h7, 16'h0000, 16'h0000), pv, rd);
			chk("ea rofs", r.ea, 16'(pv + rd));
			chk("rofs keep", r.wb_en, 1'b0);
			mod(C_MOVE, M_LOFS, S_XR, 4'h4, pv, {6'h00, rd[9:0]}, 1'b0, 16'h0000, 16'h0000);
			mod(C_MCU, M_POST, S_XR, 4'h2, pv, 16'h0002, 1'b0, 16'h0000, 16'h0000);
			mod(C_MCU, M_PRE, S_XR, 4'h2, pv, 16'hFFFC, 1'b0, 16'h0000, 16'h0000);
		end
		op(mk(C_FILE, M_FILE, S_XR, L_16, 4'h5, 4'h0, pv, 16'h0000), 16'h0000, 16'h0000);
		chk("file ea", r.ea, {3'b000, pv[12:0]});
		chk("file dst", r.dst_sel, DEFAULT_DEFAULT_WORKING_REGISTER);
		op(mk(C_MCU, M_DIR, S_XR, L_5, 4'h6, 4'h0, 16'h0000, 16'h0000), pv, 16'h0000);
		chk("direct", r.operand, pv);
		// Every literal width, branch and interrupt-disable forms among them.
		for (int i = 0; i < 6; i++) begin
			op(mk(cl_t[i], M_LIT, S_XR, lk_t[i], 4'h1, 4'h0, ~pv, 16'h0000), 16'h0000, 16'h0000);
			chk("literal", r.operand, ~pv & mk_t[i]);
		end
		// Forms that the three-operand class does not offer are refused.
		op(mk(C_MCU, M_ROFS, S_XR, L_5, 4'h1, 4'h0, 16'h0000, 16'h0000), pv, 16'h0000);
		chk("mcu rofs", r.illegal, 1'b1);
		op(mk(C_MCU, M_LIT, S_XR, L_8, 4'h1, 4'h0, pv, 16'h0000), 16'h0000, 16'h0000);
		chk("mcu lit8", r.illegal, 1'b1);
		// Multiply-accumulate: fixed spaces, steps of 2, 4 and 6, indexing only through nine and eleven.
		for (int i = 1; i <= 3; i++) begin
			mod(C_MAC, M_POST, S_Y, 4'h8, pv, 16'(2 * i), 1'b0, 16'h0000, 16'h0000);
			chk("mac x space", r.space, S_XR);
		end
		for (int i = 0; i < 8; i++) begin
			op(mk(C_MAC, mm_t[i], S_XR, L_5, mp_t[i], 4'h3, 16'h0000, 16'h0008), pv, 16'h0040);
			chk("mac illegal", r.illegal, mi_t[i]);
			chk("mac ea", r.ea, mi_t[i] ? 16'h0000 : 16'(pv + ((mm_t[i] == M_ROFS) ? 16'h0040 : 16'h0000)));
			chk("mac space", r.space, (mp_t[i] == 4'hA || mp_t[i] == 4'hB) ? S_Y : S_XR);
		end
		// X buffer of 100 bytes: wraps, overshoot, one-direction check, offset mode and disables.
		wb(1'b1, OFS_XSTART, 16'h1100);
		wb(1'b1, OFS_XEND, 16'h1163);
		wb(1'b1, OFS_MODCTL, 16'h80F1);
		mod(C_MCU, M_POST, S_XR, 4'h1, 16'h1162, 16'h0002, 1'b1, 16'h1100, 16'h1163);
		wb(1'b0, OFS_STATUS, 16'h0000);
		chk("status wrap", rd[0], 1'b1);
		mod(C_MCU, M_PRE, S_XW, 4'h1, 16'h1160, 16'h0006, 1'b1, 16'h1100, 16'h1163);
		mod(C_MCU, M_PRE, S_XR, 4'h1, 16'h1100, 16'hFFFE, 1'b1, 16'h1100, 16'h1163);
		mod(C_MCU, M_PRE, S_XR, 4'h1, 16'h10F0, 16'h0002, 1'b1, 16'h1100, 16'h1163);
		mod(C_MOVE, M_LOFS, S_XR, 4'h1, 16'h1160, 16'h0010, 1'b1, 16'h1100, 16'h1163);
		mod(C_MCU, M_POST, S_XR, 4'h2, 16'h1162, 16'h0002, 1'b0, 16'h1100, 16'h1163);
		wb(1'b1, OFS_MODCTL, 16'h00F1);
		mod(C_MCU, M_POST, S_XR, 4'h1, 16'h1162, 16'h0002, 1'b0, 16'h1100, 16'h1163);
		wb(1'b1, OFS_MODCTL, 16'h80FF);
		mod(C_MCU, M_POST, S_XR, 4'hF, 16'h1162, 16'h0002, 1'b0, 16'h1100, 16'h1163);
		// Y buffer of 32 bytes: both limits checked, low bit kept clear, enable honoured.
		wb(1'b1, OFS_YSTART, 16'h2000);
		wb(1'b1, OFS_YEND, 16'h201F);
		wb(1'b1, OFS_MODCTL, 16'h40AF);
		mod(C_MCU, M_PRE, S_Y, 4'hA, 16'h2000, 16'hFFFE, 1'b1, 16'h2000, 16'h201F);
		mod(C_MCU, M_PRE, S_Y, 4'hA, 16'h1FF0, 16'h0002, 1'b1, 16'h2000, 16'h201F);
		mod(C_MCU, M_PRE, S_Y, 4'hA, 16'h201E, 16'h0003, 1'b1, 16'h2000, 16'h201F);
		wb(1'b1, OFS_MODCTL, 16'h00AF);
		mod(C_MCU, M_PRE, S_Y, 4'hA, 16'h201E, 16'h0002, 1'b0, 16'h2000, 16'h201F);
		wrap_up();
	end
endmodule
`default_nettype wire
